// file: agp_guard_power.sv
// access guards, power mode control and slow-run clock divider
//
// Overview of operation
// RULE1: write AA then 55 to open access
// RULE2: single-use grant allows exactly one protected write
// RULE3: protected register reads always succeed; the twelve trim registers have no read path in this block
// RULE4: single-use guard covers watchdog, relocation, address ctrl
// RULE5: grant never times out; unlock access cancels
// RULE6: single-use unlock reads open state in bit0
// RULE7: windowed unlock opens 256-cycle multi-write window
// RULE8: repeating sequence restarts full window
// RULE9: writing 00 closes window at once
// RULE10: windowed unlock reads open state in bit0
// RULE11: window guards clock select, wake mask, trims
// RULE12: guards hold state while CPU clock stopped
// RULE13: sleep plus stop gates all peripheral clocks
// RULE14: hardware clears sleep and stop on exit
// RULE15: sleep also drops bandgap, main regulator
// RULE16: sleep resume slightly longer than stop resume
// RULE17: idle gates CPU and integrated peripheral clocks
// RULE18: enabled interrupt ends idle mode
// RULE19: divider bits 11 give divide by 257
// RULE20: switchback returns slow-run to full speed
// RULE21: activity status shows priorities and UART0 activity
// RULE22: software checks activity before low power entry
// RULE23: stop alone halts every clock and oscillator
// RULE24: switchback on interrupt, rx start, tx load
// RULE25: hardware clears idle bit on idle exit
// RULE26: wrong byte resets unlock sequence
// RULE27: switchback rewrites divider field to full speed
`timescale 1ns/1ps

module agp_guard_power #(
	parameter int WINDOW_LEN = agp_pkg::WINDOW_CYCLES,
	parameter int DIVIDE = agp_pkg::SLOW_DIVIDE,
	parameter int STOP_RESUME = agp_pkg::STOP_RESUME_CYCLES,
	parameter int SLEEP_EXTRA = agp_pkg::SLEEP_EXTRA_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// register port from the CPU core
	input wire agp_pkg::agp_bus_t bus,
	// peripheral activity and wake sources
	input wire agp_pkg::agp_act_t act,
	input wire logic ext_int_wake,
	input wire logic async_wake,
	// register read data
	output logic [7:0] rdata,
	// protected register contents
	output logic [7:0] watchdog_ctrl,
	output logic [7:0] memory_relocation,
	output logic [7:0] address_ctrl,
	output logic [7:0] system_clock_select,
	output logic [7:0] wake_source_mask,
	output logic [7:0] trim_reg [12],
	// clock gates, analog enables, slow-run status, cpu tick and guard open flags
	output agp_pkg::agp_gate_t gate,
	output logic slow_run_mode,
	output logic cpu_tick,
	output logic single_unlock_open_flag,
	output logic window_unlock_open_flag
);

	// =====================================================
	// register strobes
	logic wr_su, wr_wu, acc_su;
	logic [7:0] wd;
	assign wd = bus.wdata;
	assign wr_su = bus.wr && bus.addr == agp_pkg::ADDR_SINGLE_USE_UNLOCK;
	assign wr_wu = bus.wr && bus.addr == agp_pkg::ADDR_WINDOWED_UNLOCK;
	assign acc_su = (bus.wr || bus.rd) && bus.addr == agp_pkg::ADDR_SINGLE_USE_UNLOCK;

	function automatic logic is_su_prot(input logic [7:0] a);
		is_su_prot = a == agp_pkg::ADDR_WATCHDOG_CTRL || a == agp_pkg::ADDR_MEMORY_RELOCATION
			|| a == agp_pkg::ADDR_ADDRESS_CTRL;
	endfunction

	// =====================================================
	// single-use guard
	agp_pkg::agp_seq_t su_seq_r;
	logic su_open_r;
	logic su_used;
	assign su_used = su_open_r && bus.wr && is_su_prot(bus.addr);

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			su_seq_r <= agp_pkg::SEQ_IDLE;
			su_open_r <= 1'b0;
		end
		else if (clk_en && gate.cpu_clk_en) // [RULE12]
		begin
			if (wr_su)
			begin
				if (su_seq_r == agp_pkg::SEQ_GOT_AA && wd == agp_pkg::UNLOCK_SECOND)
				begin
					su_seq_r <= agp_pkg::SEQ_IDLE;
					su_open_r <= 1'b1; // [RULE1]
				end
				else
				begin
					su_seq_r <= wd == agp_pkg::UNLOCK_FIRST ? agp_pkg::SEQ_GOT_AA
						: agp_pkg::SEQ_IDLE; // [RULE26]
					su_open_r <= 1'b0; // [RULE5]
				end
			end
			else if (acc_su)
				su_open_r <= 1'b0; // [RULE5]
			else if (su_used)
				su_open_r <= 1'b0; // [RULE2]
		end
	end

	// =====================================================
	// windowed guard
	agp_pkg::agp_seq_t wu_seq_r;
	logic [8:0] wu_cnt_r;
	logic wu_open;
	assign wu_open = wu_cnt_r != 9'h000;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wu_seq_r <= agp_pkg::SEQ_IDLE;
			wu_cnt_r <= 9'h000;
		end
		else if (clk_en && gate.cpu_clk_en) // [RULE12]
		begin
			if (wr_wu && wu_seq_r == agp_pkg::SEQ_GOT_AA && wd == agp_pkg::UNLOCK_SECOND)
			begin
				wu_seq_r <= agp_pkg::SEQ_IDLE;
				wu_cnt_r <= 9'(WINDOW_LEN); // [RULE7] [RULE8]
			end
			else if (wr_wu)
			begin
				wu_seq_r <= wd == agp_pkg::UNLOCK_FIRST ? agp_pkg::SEQ_GOT_AA
					: agp_pkg::SEQ_IDLE; // [RULE26]
				if (wd == agp_pkg::WINDOW_CLOSE)
					wu_cnt_r <= 9'h000; // [RULE9]
				else if (wu_open)
					wu_cnt_r <= wu_cnt_r - 9'h001;
			end
			else if (wu_open)
				wu_cnt_r <= wu_cnt_r - 9'h001; // [RULE7]
		end
	end

	// =====================================================
	// protected registers
	logic wu_ok;
	assign wu_ok = bus.wr && wu_open && clk_en && gate.cpu_clk_en;

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			watchdog_ctrl <= agp_pkg::RST_PROTECTED;
			memory_relocation <= agp_pkg::RST_PROTECTED;
			address_ctrl <= agp_pkg::RST_PROTECTED;
		end
		else if (clk_en && gate.cpu_clk_en && su_used) // [RULE4]
		begin
			if (bus.addr == agp_pkg::ADDR_WATCHDOG_CTRL)
				watchdog_ctrl <= wd;
			else if (bus.addr == agp_pkg::ADDR_MEMORY_RELOCATION)
				memory_relocation <= wd;
			else
				address_ctrl <= wd;
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			system_clock_select <= agp_pkg::RST_SYSTEM_CLOCK_SELECT;
			wake_source_mask <= agp_pkg::RST_WAKE_SOURCE_MASK;
			for (int i = 0; i < 12; i++)
				trim_reg[i] <= agp_pkg::RST_PROTECTED;
		end
		else if (wu_ok) // [RULE11]
		begin
			if (bus.xwr && bus.xidx < 4'hC)
				trim_reg[bus.xidx] <= wd;
			else if (bus.addr == agp_pkg::ADDR_SYSTEM_CLOCK_SELECT)
				system_clock_select <= wd;
			else if (bus.addr == agp_pkg::ADDR_WAKE_SOURCE_MASK)
				wake_source_mask <= wd;
		end
	end

	// =====================================================
	// power mode control
	logic [7:0] pmc_r;
	// divider field held as {high bit, low bit, switchback enable}
	logic [2:0] cdc_r;
	agp_pkg::agp_pm_t pm_r;
	logic [6:0] resume_r;
	logic wr_pmc, wr_cdc, swb_event, swb_source;
	assign wr_pmc = bus.wr && bus.addr == agp_pkg::ADDR_POWER_MODE_CTRL && gate.cpu_clk_en;
	assign wr_cdc = bus.wr && bus.addr == agp_pkg::ADDR_CLOCK_DIVIDER_CTRL && gate.cpu_clk_en;
	// receive start only counts while the receiver is enabled
	assign swb_source = ext_int_wake
		|| act.uart0_rx_start && act.uart0_rx_enable
		|| act.uart0_tx_load; // [RULE24]
	assign swb_event = cdc_r[0] && swb_source; // [RULE20]

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pmc_r <= agp_pkg::RST_POWER_MODE_CTRL;
			pm_r <= agp_pkg::PM_RUN;
			resume_r <= 7'h00;
		end
		else if (clk_en)
		begin
			case (pm_r)
				agp_pkg::PM_RUN:
				begin
					if (wr_pmc)
					begin
						pmc_r <= wd;
						if (wd[agp_pkg::PMC_SLEEP_BIT] && wd[agp_pkg::PMC_STOP_BIT])
							pm_r <= agp_pkg::PM_SLEEP; // [RULE13]
						else if (wd[agp_pkg::PMC_STOP_BIT])
							pm_r <= agp_pkg::PM_STOP; // [RULE23]
						else if (wd[agp_pkg::PMC_IDLE_BIT])
							pm_r <= agp_pkg::PM_IDLE; // [RULE17]
					end
				end
				agp_pkg::PM_IDLE:
				begin
					if (ext_int_wake)
					begin
						pmc_r[agp_pkg::PMC_IDLE_BIT] <= 1'b0; // [RULE25]
						pm_r <= agp_pkg::PM_RUN; // [RULE18]
					end
				end
				agp_pkg::PM_STOP:
				begin
					if (async_wake)
					begin
						resume_r <= 7'(STOP_RESUME);
						pm_r <= agp_pkg::PM_RESUME;
					end
				end
				agp_pkg::PM_SLEEP:
				begin
					if (async_wake)
					begin
						resume_r <= 7'(STOP_RESUME + SLEEP_EXTRA); // [RULE16]
						pm_r <= agp_pkg::PM_RESUME;
					end
				end
				default:
				begin
					if (resume_r <= 7'h01)
					begin
						pmc_r[agp_pkg::PMC_SLEEP_BIT:0] <= 3'h0; // [RULE14]
						pm_r <= agp_pkg::PM_RUN;
					end
					else
						resume_r <= resume_r - 7'h01;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			cdc_r <= agp_pkg::RST_CLOCK_DIVIDER_CTRL;
		else if (clk_en)
		begin
			if (wr_cdc)
				cdc_r <= wd[agp_pkg::CDC_HIGH:agp_pkg::CDC_SWITCHBACK];
			else if (cdc_r[2:1] == 2'b11 && swb_event && gate.cpu_clk_en)
				cdc_r[2:1] <= 2'b01; // [RULE20] [RULE27]
		end
	end

	// =====================================================
	// slow-run divider and gates
	logic [8:0] div_r;
	logic slow;
	assign slow = cdc_r[2:1] == 2'b11; // [RULE19]

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			div_r <= 9'h000;
			cpu_tick <= 1'b0;
			slow_run_mode <= 1'b0;
		end
		else if (clk_en)
		begin
			slow_run_mode <= slow;
			if (!slow || div_r == 9'(DIVIDE - 1))
				div_r <= 9'h000;
			else
				div_r <= div_r + 9'h001;
			cpu_tick <= pm_r == agp_pkg::PM_RUN && (!slow || div_r == 9'h000); // [RULE19]
		end
	end

	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			gate <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
		else if (clk_en)
		begin
			gate.cpu_clk_en <= pm_r == agp_pkg::PM_RUN; // [RULE17] [RULE12]
			gate.int_periph_clk_en <= pm_r == agp_pkg::PM_RUN;
			gate.ext_periph_clk_en <= pm_r == agp_pkg::PM_RUN
				|| pm_r == agp_pkg::PM_IDLE; // [RULE13] [RULE23]
			gate.osc_en <= pm_r != agp_pkg::PM_STOP && pm_r != agp_pkg::PM_SLEEP;
			gate.bandgap_en <= pm_r != agp_pkg::PM_SLEEP; // [RULE15]
			gate.main_reg_en <= pm_r != agp_pkg::PM_SLEEP;
			gate.backup_reg_en <= pm_r == agp_pkg::PM_SLEEP;
		end
	end

	// =====================================================
	// read path and status flags
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata <= 8'h00;
			single_unlock_open_flag <= 1'b0;
			window_unlock_open_flag <= 1'b0;
		end
		else if (clk_en)
		begin
			single_unlock_open_flag <= su_open_r;
			window_unlock_open_flag <= wu_open;
			if (bus.rd)
			begin
				if (bus.addr == agp_pkg::ADDR_SINGLE_USE_UNLOCK)
					rdata <= {7'h00, su_open_r}; // [RULE6]
				else if (bus.addr == agp_pkg::ADDR_WINDOWED_UNLOCK)
					rdata <= {7'h00, wu_open}; // [RULE10]
				else if (bus.addr == agp_pkg::ADDR_ACTIVITY_STATUS)
					rdata <= {1'b0, act.high_prio_active, act.low_prio_active, 3'h0,
						act.uart0_tx_active, act.uart0_rx_active}; // [RULE21] [RULE22]
				else if (bus.addr == agp_pkg::ADDR_POWER_MODE_CTRL)
					rdata <= {pmc_r[agp_pkg::PMC_BAUD_DOUBLE], 7'h00};
				else if (bus.addr == agp_pkg::ADDR_CLOCK_DIVIDER_CTRL)
					rdata <= {cdc_r, 5'h00};
				else if (bus.addr == agp_pkg::ADDR_WATCHDOG_CTRL)
					rdata <= watchdog_ctrl; // [RULE3]
				else if (bus.addr == agp_pkg::ADDR_MEMORY_RELOCATION)
					rdata <= memory_relocation;
				else if (bus.addr == agp_pkg::ADDR_ADDRESS_CTRL)
					rdata <= address_ctrl;
				else if (bus.addr == agp_pkg::ADDR_SYSTEM_CLOCK_SELECT)
					rdata <= system_clock_select;
				else if (bus.addr == agp_pkg::ADDR_WAKE_SOURCE_MASK)
					rdata <= wake_source_mask;
				else
					rdata <= 8'h00;
			end
		end
	end

endmodule

// file: agp_pkg.sv
// package: constants and types for the access guard and power mode block
package agp_pkg;

	// =====================================================
	// register addresses
	localparam logic [7:0] ADDR_POWER_MODE_CTRL = 8'h87;
	localparam logic [7:0] ADDR_SYSTEM_CLOCK_SELECT = 8'h8F;
	localparam logic [7:0] ADDR_WAKE_SOURCE_MASK = 8'h9F;
	localparam logic [7:0] ADDR_ADDRESS_CTRL = 8'h9D;
	localparam logic [7:0] ADDR_CLOCK_DIVIDER_CTRL = 8'hC4;
	localparam logic [7:0] ADDR_ACTIVITY_STATUS = 8'hC5;
	localparam logic [7:0] ADDR_MEMORY_RELOCATION = 8'hC6;
	localparam logic [7:0] ADDR_SINGLE_USE_UNLOCK = 8'hC7;
	localparam logic [7:0] ADDR_WINDOWED_UNLOCK = 8'hC9;
	localparam logic [7:0] ADDR_WATCHDOG_CTRL = 8'hD8;
	// extended trim/config window (twelve registers)
	localparam logic [15:0] XADDR_BASE = 16'hA000;

	// =====================================================
	// unlock codes
	localparam logic [7:0] UNLOCK_FIRST = 8'hAA;
	localparam logic [7:0] UNLOCK_SECOND = 8'h55;
	localparam logic [7:0] WINDOW_CLOSE = 8'h00;

	// =====================================================
	// reset values
	localparam logic [7:0] RST_POWER_MODE_CTRL = 8'h00;
	localparam logic [7:0] RST_SYSTEM_CLOCK_SELECT = 8'h80;
	localparam logic [7:0] RST_WAKE_SOURCE_MASK = 8'hFF;
	localparam logic [7:0] RST_PROTECTED = 8'h00;
	localparam logic [2:0] RST_CLOCK_DIVIDER_CTRL = 3'h2;

	// =====================================================
	// field positions
	localparam int PMC_IDLE_BIT = 0;
	localparam int PMC_STOP_BIT = 1;
	localparam int PMC_SLEEP_BIT = 2;
	localparam int PMC_BAUD_DOUBLE = 7;
	localparam int CDC_SWITCHBACK = 5;
	localparam int CDC_LOW = 6;
	localparam int CDC_HIGH = 7;
	localparam int STAT_HIGH_PRIO = 6;
	localparam int STAT_LOW_PRIO = 5;
	localparam int STAT_TX = 1;
	localparam int STAT_RX = 0;

	// =====================================================
	// counts
	localparam int WINDOW_CYCLES = 256;
	localparam int SLOW_DIVIDE = 257;
	localparam int STOP_RESUME_CYCLES = 8;
	// extra regulator settle, below 64 oscillator cycles
	localparam int SLEEP_EXTRA_CYCLES = 48;

	// =====================================================
	// types
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_GOT_AA} agp_seq_t;
	typedef enum logic [2:0] {PM_RUN, PM_IDLE, PM_STOP, PM_SLEEP, PM_RESUME} agp_pm_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic xwr;
		logic [3:0] xidx;
	} agp_bus_t;

	typedef struct packed {
		logic high_prio_active;
		logic low_prio_active;
		logic uart0_tx_active;
		logic uart0_rx_active;
		logic uart0_rx_start;
		logic uart0_rx_enable;
		logic uart0_tx_load;
	} agp_act_t;

	typedef struct packed {
		logic cpu_clk_en;
		logic int_periph_clk_en;
		logic ext_periph_clk_en;
		logic osc_en;
		logic bandgap_en;
		logic main_reg_en;
		logic backup_reg_en;
	} agp_gate_t;

endpackage

// file: agp_guard_power_props.sv
// port checker for the guard and power mode block
`timescale 1ns/1ps
module agp_guard_power_props #(
	parameter int WINDOW_LEN = 256
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic clk_en,
	// requests
	input wire agp_pkg::agp_bus_t bus,
	input wire agp_pkg::agp_act_t act,
	input wire logic async_wake,
	// results
	input wire logic [7:0] rdata,
	input wire logic [7:0] memory_relocation,
	input wire agp_pkg::agp_gate_t gate,
	input wire logic slow_run_mode,
	input wire logic cpu_tick,
	input wire logic single_unlock_open_flag,
	input wire logic window_unlock_open_flag
);
	logic wr_ok;
	logic mr_wr;
	logic [3:0] act_v;
	logic [15:0] win_cnt_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	assign wr_ok = clk_en && bus.wr && gate.cpu_clk_en;
	assign mr_wr = wr_ok && bus.addr == 8'hC6;
	assign act_v = {act.high_prio_active, act.low_prio_active, act.uart0_tx_active,
		act.uart0_rx_active};
	// =====================================================
	// cpu cycles the window has stayed open
	always_ff @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			win_cnt_r <= 16'h0000;
		else if (!window_unlock_open_flag || (wr_ok && bus.addr == 8'hC9))
			win_cnt_r <= 16'h0000;
		else if (cpu_tick)
			win_cnt_r <= win_cnt_r + 16'h0001;
	end
	sequence s_wr(a, d);
		wr_ok && bus.addr == a && bus.wdata == d;
	endsequence
	sequence s_rd(a);
		clk_en && bus.rd && bus.addr == a;
	endsequence
	// =====================================================
	// properties
	AST_SU_ONCE: assert property (
		mr_wr && single_unlock_open_flag |-> ##2 !single_unlock_open_flag)
		else $error("grant kept after use");
	AST_SU_CANCEL: assert property (
		s_rd(8'hC7) ##0 single_unlock_open_flag |-> ##2 !single_unlock_open_flag)
		else $error("grant kept after unlock read");
	AST_PROT_HOLD: assert property (
		$changed(memory_relocation) |-> $past(mr_wr))
		else $error("relocation changed without write");
	AST_WIN_SHUT: assert property (
		s_wr(8'hC9, 8'h00) |-> ##2 !window_unlock_open_flag)
		else $error("window not closed");
	AST_WIN_LEN: assert property (
		win_cnt_r <= WINDOW_LEN + 2)
		else $error("window open too long");
	AST_STOP: assert property (
		s_wr(8'h87, 8'h02) |-> ##[1:3] !gate.osc_en && !gate.cpu_clk_en
		&& !gate.int_periph_clk_en && !gate.ext_periph_clk_en)
		else $error("stop left a clock running");
	AST_SLEEP: assert property (
		s_wr(8'h87, 8'h06) |-> ##[1:3] !gate.bandgap_en && !gate.main_reg_en
		&& gate.backup_reg_en && !gate.ext_periph_clk_en)
		else $error("sleep gating wrong");
	AST_IDLE: assert property (
		s_wr(8'h87, 8'h01) |-> ##[1:3] !gate.cpu_clk_en && gate.ext_periph_clk_en)
		else $error("idle gating wrong");
	AST_RESUME: assert property (
		async_wake && !gate.osc_en |-> ##[1:80] gate.cpu_clk_en && gate.osc_en)
		else $error("no resume after wake");
	AST_SLOW: assert property (
		slow_run_mode && cpu_tick |=> (!cpu_tick || !slow_run_mode) [*8])
		else $error("slow tick too soon");
	AST_STATUS: assert property (
		s_rd(8'hC5) |=> {rdata[6:5], rdata[1:0]} == $past(act_v))
		else $error("activity status wrong");
endmodule

bind agp_guard_power agp_guard_power_props #(.WINDOW_LEN(WINDOW_LEN)) u_props (
	.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .bus(bus), .act(act),
	.async_wake(async_wake), .rdata(rdata), .memory_relocation(memory_relocation),
	.gate(gate), .slow_run_mode(slow_run_mode), .cpu_tick(cpu_tick),
	.single_unlock_open_flag(single_unlock_open_flag),
	.window_unlock_open_flag(window_unlock_open_flag));

// file: agp_periph_model.sv
// peripheral and wake source model beside the guard block
`timescale 1ns/1ps
module agp_periph_model (
	// bench requests and clock gates from the guard block
	input wire logic [5:0] ev,
	input wire agp_pkg::agp_gate_t gate,
	// activity and wake lines
	output agp_pkg::agp_act_t act,
	output logic ext_int_wake,
	output logic async_wake
);
	// uart0 only active while its clock runs
	assign act = {ev[0], ev[0], ev[1] & gate.int_periph_clk_en,
		ev[1] & gate.int_periph_clk_en, ev[3], 1'h1, ev[2]};
	assign ext_int_wake = ev[4];
	assign async_wake = ev[5];
endmodule

// file: agp_guard_power_tb_top.sv
// self-checking bench for the guard and power mode block
`timescale 1ns/1ps
module agp_guard_power_tb_top;
	localparam int WL = 16;
	logic ref_clk = 1'h0;
	logic nrst = 1'h0;
	logic clk_en = 1'h1;
	logic [5:0] ev = 6'h00;
	agp_pkg::agp_bus_t bus = 23'h000000;
	agp_pkg::agp_act_t act;
	agp_pkg::agp_gate_t gate;
	logic ext_int_wake, async_wake, slow_run_mode, cpu_tick, su_f, wu_f;
	logic [7:0] rdata, cks, wkm;
	logic [7:0] pr [3];
	logic [7:0] trim [12];
	logic [7:0] pa [3] = '{8'hD8, 8'hC6, 8'h9D};
	logic [5:0] sw [4] = '{6'h04, 6'h04, 6'h08, 6'h10};
	int n_errors = 0;
	int samples_checked = 0;
	int i, n;
	int tr [2];
	always #5 ref_clk = ~ref_clk;
	agp_guard_power #(.WINDOW_LEN(WL)) DUT (
		.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .bus(bus), .act(act),
		.ext_int_wake(ext_int_wake), .async_wake(async_wake), .rdata(rdata),
		.watchdog_ctrl(pr[0]), .memory_relocation(pr[1]), .address_ctrl(pr[2]),
		.system_clock_select(cks), .wake_source_mask(wkm), .trim_reg(trim), .gate(gate),
		.slow_run_mode(slow_run_mode), .cpu_tick(cpu_tick),
		.single_unlock_open_flag(su_f), .window_unlock_open_flag(wu_f));
	agp_periph_model P (.ev(ev), .gate(gate), .act(act), .ext_int_wake(ext_int_wake),
		.async_wake(async_wake));
	// =====================================================
	// tasks
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input agp_pkg::agp_bus_t b);
		@(negedge ref_clk);
		bus = b;
	endtask
	task automatic idle(input int k);
		repeat (k) cyc(23'h000000);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cyc({2'h2, a, d, 5'h00});
	endtask
	task automatic unl(input logic [7:0] a);
		wr(a, 8'hAA);
		wr(a, 8'h55);
	endtask
	// read, mask, compare
	task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
		input string nm);
		cyc({2'h1, a, 8'h00, 5'h00});
		cyc(23'h000000);
		chk(rdata & m, e, nm);
	endtask
	task automatic wait_cpu(output int c);
		c = 0;
		while (gate.cpu_clk_en !== 1'h1 && c < 200)
		begin
			@(negedge ref_clk);
			c++;
		end
		if (c == 200)
		begin
			n_errors++;
			results();
		end
	endtask
	// =====================================================
	// main sequence
	initial
	begin
		idle(2);
		nrst = 1'h1;
		rc(8'h8F, 8'hFF, 8'h80, "system_clock_select");
		rc(8'h9F, 8'hFF, 8'hFF, "wake_source_mask");
		rc(8'hC4, 8'hE0, 8'h40, "divider");
		for (i = 0; i < 3; i++)
		begin
			wr(pa[i], 8'h5A);
			rc(pa[i], 8'hFF, 8'h00, "locked");
			unl(8'hC7);
			wr(pa[i], 8'h3C);
			wr(pa[i], 8'h77);
			rc(pa[i], 8'hFF, 8'h3C, "once");
			chk(pr[i], 8'h3C, "port");
		end
		wr(8'hC7, 8'hAA);
		wr(8'hC7, 8'h12);
		wr(8'hC7, 8'h55);
		wr(8'hC6, 8'h99);
		rc(8'hC6, 8'hFF, 8'h3C, "badseq");
		unl(8'hC7);
		rc(8'hC7, 8'h01, 8'h01, "suflag");
		wr(8'hC6, 8'h99);
		rc(8'hC6, 8'hFF, 8'h3C, "cancel");
		unl(8'hC7);
		idle(300);
		wr(8'hC6, 8'h11);
		rc(8'hC6, 8'hFF, 8'h11, "notime");
		// window guard
		unl(8'hC9);
		wr(8'h8F, 8'h81);
		wr(8'h9F, 8'h0F);
		cyc({2'h2, 8'h00, 8'hA5, 5'h1B});
		rc(8'hC9, 8'h01, 8'h01, "wbopen");
		idle(WL);
		wr(8'h8F, 8'h82);
		cyc({2'h2, 8'h00, 8'h5A, 5'h10});
		rc(8'h8F, 8'hFF, 8'h81, "expired");
		chk(wkm, 8'h0F, "wkm");
		chk(trim[11], 8'hA5, "trim11");
		chk(trim[0], 8'h00, "trim0");
		unl(8'hC9);
		idle(WL - 4);
		unl(8'hC9);
		idle(WL - 4);
		wr(8'h8F, 8'h83);
		rc(8'h8F, 8'hFF, 8'h83, "restart");
		wr(8'hC9, 8'h00);
		wr(8'h8F, 8'h84);
		rc(8'hC9, 8'h01, 8'h00, "wbshut");
		rc(8'h8F, 8'hFF, 8'h83, "close");
		// idle with an open window
		unl(8'hC9);
		wr(8'h87, 8'h01);
		idle(3 * WL);
		chk(wu_f, 8'h01, "frozen");
		chk(gate.ext_periph_clk_en, 8'h01, "extclk");
		chk(gate.cpu_clk_en | gate.int_periph_clk_en, 8'h00, "cpuclk");
		ev = 6'h10;
		wait_cpu(n);
		ev = 6'h00;
		idle(4);
		chk(gate.cpu_clk_en, 8'h01, "idleclr");
		wr(8'hC9, 8'h00);
		// stop, then sleep
		for (i = 0; i < 2; i++)
		begin
			rc(8'hC5, 8'hFF, 8'h00, "quiet");
			wr(8'h87, (i != 0) ? 8'h06 : 8'h02);
			idle(4);
			chk(gate.osc_en | gate.ext_periph_clk_en, 8'h00, "allstop");
			chk(gate.bandgap_en, {7'h00, i == 0}, "bandgap");
			ev = 6'h20;
			wait_cpu(tr[i]);
			ev = 6'h00;
			idle(4);
			chk(gate.ext_periph_clk_en, 8'h01, "woken");
		end
		chk({7'h00, tr[1] > tr[0] && tr[1] - tr[0] < 64}, 8'h01, "resume");
		// slow run and switchback
		wr(8'hC4, 8'hC0);
		idle(2);
		n = 0;
		repeat (514)
		begin
			@(negedge ref_clk);
			n += cpu_tick;
		end
		chk(n[7:0], 8'h02, "ticks");
		for (i = 0; i < 4; i++)
		begin
			wr(8'hC4, (i != 0) ? 8'hE0 : 8'hC0);
			idle(2);
			ev = sw[i];
			idle(1);
			ev = 6'h00;
			idle(3);
			chk(slow_run_mode, {7'h00, i == 0}, "slow");
			rc(8'hC4, 8'hC0, (i != 0) ? 8'h40 : 8'hC0, "div");
		end
		ev = 6'h03;
		rc(8'hC5, 8'h63, 8'h63, "active");
		ev = 6'h00;
		results();
	end
endmodule
